//--- design/dcrp_cfg.svh
`ifndef DCRP_CFG_SVH
`define DCRP_CFG_SVH

// Register offsets
`define DCRP_ADDR_LOOP_CTRL   8'h30
`define DCRP_ADDR_RANK_UPPER  8'h31
`define DCRP_ADDR_RANK_LOWER  8'h32
`define DCRP_ADDR_VAR_BW      8'hBB

// Reset values
`define DCRP_RST_LOOP_CTRL    8'h0C
`define DCRP_RST_RANK_UPPER   8'h32
`define DCRP_RST_RANK_LOWER   8'h10
`define DCRP_RDATA_UNMAPPED   8'h00

// Field positions
`define DCRP_SLOPE_LSB        2
`define DCRP_SLOPE_MSB        3
`define DCRP_TIE_CLR_BIT      4
`define DCRP_BW_LSB           5
`define DCRP_BW_MSB           7
`define DCRP_RANK_TWO_LSB     0
`define DCRP_RANK_TWO_MSB     2
`define DCRP_RANK_THREE_LSB   4
`define DCRP_RANK_THREE_MSB   6

// Special codes
`define DCRP_RANK_DISABLED    3'h7
`define DCRP_BW_VARIABLE      3'h7

// Phase slope limits in ns/s
`define DCRP_SLOPE_61_NSPS    16'hEE48
`define DCRP_SLOPE_7P5_NSPS   16'h1D4C
`define DCRP_SLOPE_0P885_NSPS 16'h0375
`define DCRP_SLOPE_NONE_NSPS  16'h0000

// Fixed loop bandwidths in Hz
`define DCRP_BW_14_HZ         10'h00E
`define DCRP_BW_28_HZ         10'h01C
`define DCRP_BW_56_HZ         10'h038
`define DCRP_BW_112_HZ        10'h070
`define DCRP_BW_224_HZ        10'h0E0
`define DCRP_BW_448_HZ        10'h1C0
`define DCRP_BW_896_HZ        10'h380
`define DCRP_BW_NONE_HZ       10'h000

`endif

//--- design/dcrp_pkg.sv
package dcrp_pkg;

  typedef logic [2:0] dcrp_rank_t;

  typedef enum logic [1:0] {
    DCRP_SLOPE_61    = 2'b00,
    DCRP_SLOPE_7P5   = 2'b01,
    DCRP_SLOPE_0P885 = 2'b10,
    DCRP_SLOPE_NONE  = 2'b11
  } dcrp_slope_t;

  typedef enum logic [2:0] {
    DCRP_BW_14  = 3'b000,
    DCRP_BW_28  = 3'b001,
    DCRP_BW_56  = 3'b010,
    DCRP_BW_112 = 3'b011,
    DCRP_BW_224 = 3'b100,
    DCRP_BW_448 = 3'b101,
    DCRP_BW_896 = 3'b110,
    DCRP_BW_VAR = 3'b111
  } dcrp_bw_t;

endpackage

//--- design/dcrp_sel_if.sv
`timescale 1ns/100ps
`default_nettype none

interface dcrp_sel_if #(
  parameter int NREF = 2,
  parameter int IW   = 1
);
  dcrp_pkg::dcrp_rank_t [NREF-1:0] rank;
  logic [NREF-1:0]                 ref_failed;
  logic                            auto_en;
  logic [IW-1:0]                   sel_idx;
  logic                            sel_valid;

  modport reg_side (output rank, output ref_failed, output auto_en,
                    input sel_idx, input sel_valid);
  modport sel_side (input rank, input ref_failed, input auto_en,
                    output sel_idx, output sel_valid);
endinterface

`default_nettype wire

//--- design/dcrp_ref_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcrp_cfg.svh"

module dcrp_ref_select #(
  parameter int NREF = 2,
  parameter int IW   = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Selection link
  dcrp_sel_if.sel_side sel
);

  logic [NREF-1:0]      elig;
  logic                 any_elig;
  dcrp_pkg::dcrp_rank_t best_rank;
  logic [IW-1:0]        best_idx;
  dcrp_pkg::dcrp_rank_t cur_rank;
  logic                 keep;
  logic [IW-1:0]        sel_idx_r;
  logic                 sel_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Eligibility per reference
  genvar g;
  for (g = 0; g < NREF; g++) begin : g_elig
    assign elig[g] = !sel.ref_failed[g] && (sel.rank[g] != `DCRP_RANK_DISABLED); // R7
  end

  assign any_elig = |elig;

  // Lowest rank number wins, lowest index breaks ties
  always_comb begin
    best_rank = `DCRP_RANK_DISABLED;
    best_idx  = '0;
    for (int i = NREF - 1; i >= 0; i--) begin
      if (elig[i] && (sel.rank[i] <= best_rank)) begin // R6 R12
        best_rank = sel.rank[i];
        best_idx  = IW'(i);
      end
    end
  end

  assign cur_rank = sel.rank[sel_idx_r];
  assign keep     = sel_valid_r && elig[sel_idx_r] && (cur_rank == best_rank); // R9 R10

  ////////////////////////////////////////////////////////////////////////////
  // Selected reference
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_idx_r   <= '0;
      sel_valid_r <= 1'b0;
    end else if (sel.auto_en) begin
      if (!any_elig) begin
        sel_valid_r <= 1'b0;
      end else if (!keep) begin
        sel_idx_r   <= best_idx; // R8 R10
        sel_valid_r <= 1'b1;
      end
    end
  end

  assign sel.sel_idx   = sel_idx_r;
  assign sel.sel_valid = sel_valid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  revert_to_best_a: assert property ( // R8
    sel.auto_en && any_elig && sel_valid_r && (best_rank < cur_rank)
    |=> sel.sel_valid && (sel.sel_idx == $past(best_idx)))
    else $error("better ranked reference not taken");

  equal_rank_hold_a: assert property ( // R9
    sel.auto_en && keep |=> sel.sel_valid && $stable(sel.sel_idx))
    else $error("switched within equal rank");

  disabled_never_a: assert property ( // R7
    sel.auto_en && any_elig && !keep
    |=> sel.sel_valid && (sel.rank[sel.sel_idx] != `DCRP_RANK_DISABLED || $changed(sel.rank)))
    else $error("disabled reference selected");

  holdover_drop_a: assert property ( // R10
    sel.auto_en && !any_elig |=> !sel.sel_valid)
    else $error("selection kept with no eligible reference");

endmodule // dcrp_ref_select

`default_nettype wire

//--- design/dcrp_regs.sv
//
// Contract
// [R1] Slope code sets phase slew limit
// [R2] Offset-clear bit requests output phase alignment
// [R3] Software keeps offset-clear low for hitless switching
// [R4] Bandwidth code 000..110 gives 14..896 Hz
// [R5] Bandwidth code 111 uses variable setting
// [R6] Input two rank bits 2:0, 000 highest
// [R7] Rank 111 excludes reference from selection
// [R8] Different ranks switch revertively to lowest
// [R9] Equal ranks switch non-revertively
// [R10] Mixed ranks combine both switching behaviours
// [R11] Input three rank at bits 6:4
// [R12] Codes 011..110 are ranks four..seven
// [R13] Reserved bits stored, read back, unused
//
`timescale 1ns/100ps
`default_nettype none
`include "dcrp_cfg.svh"

module dcrp_regs #(
  parameter int NREF = 2,
  parameter int IW   = 1
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Host register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // Loop filter controls
  input  wire logic [7:0] variable_bandwidth_setting,
  output logic     [15:0] slope_limit_nsps,
  output logic            slope_unlimited,
  output logic            phase_align_req,
  output logic      [9:0] loop_bandwidth_hz,
  output logic            use_variable_bandwidth,
  output logic      [7:0] variable_bandwidth_out,
  // Reference switching
  input  wire logic       auto_switch_en,
  input  wire logic [1:0] ref_failed,
  output logic      [2:0] input_two_rank,
  output logic      [2:0] input_three_rank,
  output logic            selected_ref,
  output logic            selected_valid
);

  logic [7:0]  loop_ctrl_r;
  logic [7:0]  rank_upper_r;
  logic [7:0]  rank_lower_r;
  logic [7:0]  rdata_nxt;
  logic [7:0]  reg_rdata_r;
  logic        reg_rvalid_r;

  logic [15:0] slope_nsps_nxt;
  logic [9:0]  bw_hz_nxt;
  logic [15:0] slope_nsps_r;
  logic        slope_unl_r;
  logic        phase_align_r;
  logic [9:0]  bw_hz_r;
  logic        use_var_r;
  logic [7:0]  var_bw_r;

  dcrp_pkg::dcrp_slope_t slope_code;
  dcrp_pkg::dcrp_bw_t    bw_code;

  dcrp_sel_if #(.NREF(NREF), .IW(IW)) sel_link ();

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_ctrl_r <= `DCRP_RST_LOOP_CTRL;
    end else if (reg_wr && (reg_addr == `DCRP_ADDR_LOOP_CTRL)) begin
      loop_ctrl_r <= reg_wdata; // R13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rank_upper_r <= `DCRP_RST_RANK_UPPER;
    end else if (reg_wr && (reg_addr == `DCRP_ADDR_RANK_UPPER)) begin
      rank_upper_r <= reg_wdata; // R13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rank_lower_r <= `DCRP_RST_RANK_LOWER;
    end else if (reg_wr && (reg_addr == `DCRP_ADDR_RANK_LOWER)) begin
      rank_lower_r <= reg_wdata; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  always_comb begin
    if (reg_addr == `DCRP_ADDR_LOOP_CTRL) begin
      rdata_nxt = loop_ctrl_r;
    end else if (reg_addr == `DCRP_ADDR_RANK_UPPER) begin
      rdata_nxt = rank_upper_r;
    end else if (reg_addr == `DCRP_ADDR_RANK_LOWER) begin
      rdata_nxt = rank_lower_r;
    end else begin
      rdata_nxt = `DCRP_RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_r  <= `DCRP_RDATA_UNMAPPED;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  assign reg_rdata  = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Loop control decode
  assign slope_code = dcrp_pkg::dcrp_slope_t'(loop_ctrl_r[`DCRP_SLOPE_MSB:`DCRP_SLOPE_LSB]);
  assign bw_code    = dcrp_pkg::dcrp_bw_t'(loop_ctrl_r[`DCRP_BW_MSB:`DCRP_BW_LSB]);

  always_comb begin
    case (slope_code)
      dcrp_pkg::DCRP_SLOPE_61:    slope_nsps_nxt = `DCRP_SLOPE_61_NSPS; // R1
      dcrp_pkg::DCRP_SLOPE_7P5:   slope_nsps_nxt = `DCRP_SLOPE_7P5_NSPS;
      dcrp_pkg::DCRP_SLOPE_0P885: slope_nsps_nxt = `DCRP_SLOPE_0P885_NSPS;
      default:                    slope_nsps_nxt = `DCRP_SLOPE_NONE_NSPS;
    endcase
  end

  always_comb begin
    case (bw_code)
      dcrp_pkg::DCRP_BW_14:  bw_hz_nxt = `DCRP_BW_14_HZ; // R4
      dcrp_pkg::DCRP_BW_28:  bw_hz_nxt = `DCRP_BW_28_HZ;
      dcrp_pkg::DCRP_BW_56:  bw_hz_nxt = `DCRP_BW_56_HZ;
      dcrp_pkg::DCRP_BW_112: bw_hz_nxt = `DCRP_BW_112_HZ;
      dcrp_pkg::DCRP_BW_224: bw_hz_nxt = `DCRP_BW_224_HZ;
      dcrp_pkg::DCRP_BW_448: bw_hz_nxt = `DCRP_BW_448_HZ;
      dcrp_pkg::DCRP_BW_896: bw_hz_nxt = `DCRP_BW_896_HZ;
      default:               bw_hz_nxt = `DCRP_BW_NONE_HZ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slope limit outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      slope_nsps_r <= `DCRP_SLOPE_NONE_NSPS;
      slope_unl_r  <= 1'b0;
    end else begin
      slope_nsps_r <= slope_nsps_nxt; // R1
      slope_unl_r  <= (slope_code == dcrp_pkg::DCRP_SLOPE_NONE); // R1
    end
  end

  // Phase alignment request
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_align_r <= 1'b0;
    end else begin
      phase_align_r <= loop_ctrl_r[`DCRP_TIE_CLR_BIT]; // R2
    end
  end

  // Loop bandwidth outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      bw_hz_r   <= `DCRP_BW_NONE_HZ;
      use_var_r <= 1'b0;
      var_bw_r  <= 8'h00;
    end else begin
      bw_hz_r   <= bw_hz_nxt; // R4
      use_var_r <= (bw_code == dcrp_pkg::DCRP_BW_VAR); // R5
      var_bw_r  <= (bw_code == dcrp_pkg::DCRP_BW_VAR) ? variable_bandwidth_setting : 8'h00; // R5
    end
  end

  assign slope_limit_nsps       = slope_nsps_r;
  assign slope_unlimited        = slope_unl_r;
  assign phase_align_req        = phase_align_r;
  assign loop_bandwidth_hz      = bw_hz_r;
  assign use_variable_bandwidth = use_var_r;
  assign variable_bandwidth_out = var_bw_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reference ranks and selection
  assign sel_link.rank[0]    = rank_upper_r[`DCRP_RANK_TWO_MSB:`DCRP_RANK_TWO_LSB]; // R6
  assign sel_link.rank[1]    = rank_upper_r[`DCRP_RANK_THREE_MSB:`DCRP_RANK_THREE_LSB]; // R11
  assign sel_link.ref_failed = ref_failed;
  assign sel_link.auto_en    = auto_switch_en;

  dcrp_ref_select #(.NREF(NREF), .IW(IW)) u_select (
    .clk (clk),
    .rst (rst),
    .sel (sel_link.sel_side)
  );

  assign input_two_rank   = rank_upper_r[`DCRP_RANK_TWO_MSB:`DCRP_RANK_TWO_LSB];
  assign input_three_rank = rank_upper_r[`DCRP_RANK_THREE_MSB:`DCRP_RANK_THREE_LSB];
  assign selected_ref     = sel_link.sel_idx[0];
  assign selected_valid   = sel_link.sel_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ctrl_write_s;
    reg_wr && (reg_addr == `DCRP_ADDR_LOOP_CTRL);
  endsequence

  sequence ctrl_read_s;
    reg_rd && !reg_wr && (reg_addr == `DCRP_ADDR_LOOP_CTRL);
  endsequence

  reg_reset_val_a: assert property ( // R13
    $past(rst) |-> (loop_ctrl_r == `DCRP_RST_LOOP_CTRL)
      && (rank_upper_r == `DCRP_RST_RANK_UPPER)
      && (rank_lower_r == `DCRP_RST_RANK_LOWER))
    else $error("register reset value wrong");

  write_read_back_a: assert property ( // R13
    ctrl_write_s ##1 ctrl_read_s |=> reg_rvalid && (reg_rdata == $past(reg_wdata, 2)))
    else $error("written control byte not read back");

  unmapped_read_a: assert property (
    reg_rd && (reg_addr != `DCRP_ADDR_LOOP_CTRL) && (reg_addr != `DCRP_ADDR_RANK_UPPER)
      && (reg_addr != `DCRP_ADDR_RANK_LOWER)
    |=> reg_rvalid && (reg_rdata == `DCRP_RDATA_UNMAPPED))
    else $error("unmapped read not zero");

  slope_limit_map_a: assert property ( // R1
    ctrl_write_s and (reg_wdata[`DCRP_SLOPE_MSB:`DCRP_SLOPE_LSB] == 2'h0)
    |=> ##1 (slope_limit_nsps == `DCRP_SLOPE_61_NSPS) && !slope_unlimited)
    else $error("slope code 00 not 61 us/s");

  slope_free_a: assert property ( // R1
    (slope_code == dcrp_pkg::DCRP_SLOPE_NONE) |=> slope_unlimited
      && (slope_limit_nsps == `DCRP_SLOPE_NONE_NSPS))
    else $error("slope code 11 not unlimited");

  phase_align_a: assert property ( // R2
    ctrl_write_s |=> ##1 (phase_align_req == $past(reg_wdata[`DCRP_TIE_CLR_BIT], 2)))
    else $error("phase align request does not follow bit 4");

  bw_fixed_map_a: assert property ( // R4
    (bw_code == dcrp_pkg::DCRP_BW_896) ##1 (bw_code == dcrp_pkg::DCRP_BW_896)
    |=> (loop_bandwidth_hz == `DCRP_BW_896_HZ) && !use_variable_bandwidth)
    else $error("bandwidth code 110 not 896 Hz");

  bw_variable_a: assert property ( // R5
    (bw_code == dcrp_pkg::DCRP_BW_VAR)
    |=> use_variable_bandwidth && (variable_bandwidth_out == $past(variable_bandwidth_setting)))
    else $error("variable bandwidth not taken");

  rank_field_map_a: assert property ( // R11
    reg_wr && (reg_addr == `DCRP_ADDR_RANK_UPPER)
    |=> (input_three_rank == $past(reg_wdata[`DCRP_RANK_THREE_MSB:`DCRP_RANK_THREE_LSB]))
      && (input_two_rank == $past(reg_wdata[`DCRP_RANK_TWO_MSB:`DCRP_RANK_TWO_LSB])))
    else $error("rank fields misplaced");

  rvalid_pulse_a: assert property (
    1'b1 |=> (reg_rvalid == $past(reg_rd)))
    else $error("read valid not one cycle after strobe");

  rdata_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  ctrl_hold_a: assert property ( // R13
    !(reg_wr && (reg_addr == `DCRP_ADDR_LOOP_CTRL)) |=> $stable(loop_ctrl_r))
    else $error("control byte changed without a write");

  unmapped_write_a: assert property ( // R13
    reg_wr && (reg_addr != `DCRP_ADDR_LOOP_CTRL) && (reg_addr != `DCRP_ADDR_RANK_UPPER)
      && (reg_addr != `DCRP_ADDR_RANK_LOWER)
    |=> $stable(rank_upper_r) && $stable(rank_lower_r) && $stable(loop_ctrl_r))
    else $error("unmapped write changed a register");

  slope_mid_map_a: assert property ( // R1
    (slope_code == dcrp_pkg::DCRP_SLOPE_7P5)
    |=> (slope_limit_nsps == `DCRP_SLOPE_7P5_NSPS) && !slope_unlimited)
    else $error("slope code 01 not 7.5 us/s");

  slope_fine_map_a: assert property ( // R1
    (slope_code == dcrp_pkg::DCRP_SLOPE_0P885)
    |=> (slope_limit_nsps == `DCRP_SLOPE_0P885_NSPS) && !slope_unlimited)
    else $error("slope code 10 not 0.885 us/s");

  bw_low_map_a: assert property ( // R4
    (bw_code == dcrp_pkg::DCRP_BW_14)
    |=> (loop_bandwidth_hz == `DCRP_BW_14_HZ) && !use_variable_bandwidth)
    else $error("bandwidth code 000 not 14 Hz");

  var_bw_idle_a: assert property ( // R5
    (bw_code != dcrp_pkg::DCRP_BW_VAR)
    |=> !use_variable_bandwidth && (variable_bandwidth_out == 8'h00))
    else $error("variable bandwidth used with fixed code");

endmodule // dcrp_regs

`default_nettype wire

//--- bench/dcrp_tb.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, (e), (g)); end end

module testbench;
  ////////////////////////////////////////////////////////////////////////////////
  // Signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [7:0]  variable_bandwidth_setting = 8'h00;
  logic [15:0] slope_limit_nsps;
  logic        slope_unlimited;
  logic        phase_align_req;
  logic [9:0]  loop_bandwidth_hz;
  logic        use_variable_bandwidth;
  logic [7:0]  variable_bandwidth_out;
  logic        auto_switch_en = 1'b1;
  logic [1:0]  ref_failed = 2'b00;
  logic [2:0]  input_two_rank;
  logic [2:0]  input_three_rank;
  logic        selected_ref;
  logic        selected_valid;
  int          failures = 0;
  int          total_checks = 0;
  integer      seed = 32'h84F8FB6C;
  logic [7:0]  m_ranks = 8'h32;
  logic [1:0]  m_fail = 2'b00;
  logic        m_auto = 1'b1;
  logic        m_valid = 1'b0;
  logic        m_ref = 1'b0;

  always #10 clk = ~clk;

  dcrp_regs DUT (
    .clk                        (clk),
    .rst                        (rst),
    .reg_addr                   (reg_addr),
    .reg_wr                     (reg_wr),
    .reg_wdata                  (reg_wdata),
    .reg_rd                     (reg_rd),
    .reg_rdata                  (reg_rdata),
    .reg_rvalid                 (reg_rvalid),
    .variable_bandwidth_setting (variable_bandwidth_setting),
    .slope_limit_nsps           (slope_limit_nsps),
    .slope_unlimited            (slope_unlimited),
    .phase_align_req            (phase_align_req),
    .loop_bandwidth_hz          (loop_bandwidth_hz),
    .use_variable_bandwidth     (use_variable_bandwidth),
    .variable_bandwidth_out     (variable_bandwidth_out),
    .auto_switch_en             (auto_switch_en),
    .ref_failed                 (ref_failed),
    .input_two_rank             (input_two_rank),
    .input_three_rank           (input_three_rank),
    .selected_ref               (selected_ref),
    .selected_valid             (selected_valid)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Expectations
  function automatic logic [15:0] slope_exp(input logic [1:0] c);
    case (c)
      2'h0: return 16'hEE48;
      2'h1: return 16'h1D4C;
      2'h2: return 16'h0375;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic [9:0] bw_exp(input logic [2:0] c);
    if (c == 3'h7) return 10'h000;
    return 10'h00E << c;
  endfunction

  task automatic model_upd();
    logic [2:0] r0;
    logic [2:0] r1;
    logic       e0;
    logic       e1;
    r0 = m_ranks[2:0];
    r1 = m_ranks[6:4];
    e0 = !m_fail[0] && (r0 != 3'h7);
    e1 = !m_fail[1] && (r1 != 3'h7);
    if (m_auto) begin
      if (!e0 && !e1) begin
        m_valid = 1'b0;
      end else if (m_valid && (m_ref ? e1 : e0)) begin
        if (m_ref && e0 && (r0 < r1)) m_ref = 1'b0;
        else if (!m_ref && e1 && (r1 < r0)) m_ref = 1'b1;
      end else begin
        m_valid = 1'b1;
        m_ref   = !e0 || (e1 && (r1 < r0));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    `CHK("wr_rd_valid", 1'b1, reg_rvalid)
    q = reg_rdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    if (n == 4) begin
      failures++;
      $display("BAD read_valid expected 1 seen %b", reg_rvalid);
    end
    d = reg_rdata;
  endtask

  task automatic check_sel();
    `CHK("sel_valid", m_valid, selected_valid)
    if (m_valid) `CHK("sel_ref", m_ref, selected_ref)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Tests
  task automatic reset_test();
    logic [7:0] d;
    rd(8'h30, d); `CHK("rst_loop", 8'h0C, d)
    rd(8'h31, d); `CHK("rst_upper", 8'h32, d)
    rd(8'h32, d); `CHK("rst_lower", 8'h10, d)
    `CHK("rst_unlim", 1'b1, slope_unlimited)
    `CHK("rst_bw", 10'h00E, loop_bandwidth_hz)
    model_upd();
    check_sel();
    $display("Test reset done");
  endtask

  task automatic loop_test();
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  q;
    for (int i = 0; i < 64; i++) begin
      r = $random(seed);
      d = {i[5:0], r[1:0]};
      variable_bandwidth_setting = r[15:8];
      wr_rd(8'h30, d, q); `CHK("rb_now", d, q)
      wr(8'hBB, r[23:16]);
      wr(8'h32, r[31:24]);
      repeat (3) @(negedge clk);
      `CHK("slope", slope_exp(d[3:2]), slope_limit_nsps)
      `CHK("unlim", d[3:2] == 2'h3, slope_unlimited)
      `CHK("align", d[4], phase_align_req)
      `CHK("bw_hz", bw_exp(d[7:5]), loop_bandwidth_hz)
      `CHK("use_var", d[7:5] == 3'h7, use_variable_bandwidth)
      `CHK("var_bw", (d[7:5] == 3'h7) ? r[15:8] : 8'h00, variable_bandwidth_out)
      rd(8'h30, q); `CHK("rb_loop", d, q)
      rd(8'hBB, q); `CHK("rb_unmapped", 8'h00, q)
      rd(8'h32, q); `CHK("rb_lower", r[31:24], q)
    end
    wr(8'h30, 8'h0C);
    $display("Test loop control done");
  endtask

  task automatic sel_step(input logic [7:0] rk, input logic [1:0] f, input logic a);
    logic [7:0] d;
    auto_switch_en = a;
    m_auto = a;
    repeat (3) @(negedge clk);
    model_upd();
    wr(8'h31, rk);
    m_ranks = rk;
    repeat (3) @(negedge clk);
    model_upd();
    check_sel();
    ref_failed = f;
    m_fail = f;
    repeat (3) @(negedge clk);
    model_upd();
    check_sel();
    `CHK("rank_two", rk[2:0], input_two_rank)
    `CHK("rank_three", rk[6:4], input_three_rank)
    rd(8'h31, d); `CHK("rb_upper", rk, d)
  endtask

  task automatic sel_test();
    logic [10:0] corner [9];
    logic [31:0] r;
    corner = '{11'h400, 11'h500, 11'h400, 11'h430, 11'h437,
               11'h637, 11'h445, 11'h245, 11'h445};
    foreach (corner[k]) sel_step(corner[k][7:0], corner[k][9:8], corner[k][10]);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      sel_step(r[7:0], r[9:8], r[11:10] != 2'h0);
    end
    $display("Test selection done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    reset_test();
    loop_test();
    rst = 1'b1;
    m_valid = 1'b0;
    m_ranks = 8'h32;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    reset_test();
    sel_test();
    wrap_up();
  end

  initial begin
    #400000;
    failures++;
    $display("BAD watchdog expected done seen hang");
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
